//--- design/codec_mode_pkg.sv
package codec_mode_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned GAIN_W = 7;
   localparam int unsigned TMO_W  = 13;

   // Word index of each register; the byte address is four times the index.
   localparam logic [2:0] IDX_INPUT_SOURCE = 3'h0;
   localparam logic [2:0] IDX_POWER_MGMT   = 3'h1;
   localparam logic [2:0] IDX_FORMAT       = 3'h2;
   localparam logic [2:0] IDX_GAIN_TIMING  = 3'h3;
   localparam logic [2:0] IDX_GAIN_LEFT    = 3'h4;
   localparam logic [2:0] IDX_GAIN_RIGHT   = 3'h5;
   localparam logic [2:0] IDX_STATUS       = 3'h6;

   typedef struct packed {
      logic [3:0] reserved;
      logic       right_input_b_on;
      logic       right_input_a_on;
      logic       left_input_b_on;
      logic       left_input_a_on;
   } input_source_t;

   typedef struct packed {
      logic [3:0] reserved;
      logic       loopback_power_select;
      logic       dac_power;
      logic       adc_power;
      logic       front_end_power;
   } power_mgmt_t;

   typedef enum logic [1:0] {
      FMT_MSB_OUT_LSB_IN = 2'h0,
      FMT_LSB_64FS       = 2'h1,
      FMT_MSB_BOTH       = 2'h2,
      FMT_I2S_BOTH       = 2'h3
   } serial_format_t;

   typedef enum logic [1:0] {
      DEEMPH_44K1 = 2'h0,
      DEEMPH_OFF  = 2'h1,
      DEEMPH_48K  = 2'h2,
      DEEMPH_32K  = 2'h3
   } deemph_rate_t;

   typedef struct packed {
      logic [1:0]     mono_mix_sel;
      serial_format_t serial_format_sel;
      deemph_rate_t   deemph_rate_sel;
      logic           deemph_enable;
      logic           reserved;
   } format_t;

   typedef struct packed {
      logic       gain_link_mode;
      logic       input_range_sel;
      logic [1:0] host_recovery_timeout_sel;
      logic       host_recovery_zc_enable;
      logic [1:0] limiter_timing_sel;
      logic       limiter_zc_enable;
   } timing_t;

   typedef struct packed {
      logic front_end_on;
      logic adc_on;
      logic dac_on;
      logic loopback_on;
      logic out_amp_on;
      logic amp_from_loopback;
      logic device_on;
   } power_ctrl_t;

   typedef struct packed {
      logic left;
      logic right;
   } chan_pair_t;

   typedef struct packed {
      logic [6:0]        reserved3;
      logic              device_on;
      logic              reserved2;
      logic [GAIN_W-1:0] right_gain;
      logic              reserved1;
      logic [GAIN_W-1:0] left_gain;
      logic [5:0]        reserved0;
      logic              right_pending;
      logic              left_pending;
   } status_t;

   localparam input_source_t INPUT_SOURCE_RST = 8'h05;
   localparam power_mgmt_t   POWER_MGMT_RST   = 8'h07;
   localparam format_t       FORMAT_RST       = 8'h00;
   localparam timing_t       GAIN_TIMING_RST  = 8'hE4;
   localparam logic [GAIN_W-1:0] GAIN_RST     = 7'h00;

   // Timeouts and update periods, in sample periods.
   localparam logic [TMO_W-1:0] HR_TMO_0  = 13'h0201;
   localparam logic [TMO_W-1:0] HR_TMO_1  = 13'h0401;
   localparam logic [TMO_W-1:0] HR_TMO_2  = 13'h0801;
   localparam logic [TMO_W-1:0] HR_TMO_3  = 13'h1001;
   localparam logic [TMO_W-1:0] LIM_TMO_0 = 13'h0081;
   localparam logic [TMO_W-1:0] LIM_TMO_1 = 13'h0102;
   localparam logic [TMO_W-1:0] LIM_TMO_2 = 13'h0204;
   localparam logic [TMO_W-1:0] LIM_TMO_3 = 13'h0408;
   localparam logic [TMO_W-1:0] LIM_UPD_0 = 13'h0001;
   localparam logic [TMO_W-1:0] LIM_UPD_1 = 13'h0002;
   localparam logic [TMO_W-1:0] LIM_UPD_2 = 13'h0004;
   localparam logic [TMO_W-1:0] LIM_UPD_3 = 13'h0008;

endpackage

//--- design/gain_change_unit.sv
`timescale 1ns/100ps
`default_nettype none

module gain_change_unit
   import codec_mode_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              reset_n,
   input  wire logic              clear,
   input  wire logic              sample_tick,
   input  wire logic              sign_in,
   input  wire logic              req,
   input  wire logic [GAIN_W-1:0] req_value,
   input  wire logic              req_zc,
   input  wire logic [TMO_W-1:0]  req_limit,
   output logic      [GAIN_W-1:0] applied_gain,
   output logic                   pending
);

   typedef enum logic {ST_IDLE, ST_WAIT} unit_state_t;

   unit_state_t       state_q;
   logic [GAIN_W-1:0] target_q;
   logic [TMO_W-1:0]  limit_q;
   logic [TMO_W-1:0]  cnt_q;
   logic              last_sign_q;
   logic              sign_valid_q;
   logic              zc_seen;
   logic              timed_out;

   assign zc_seen   = sign_valid_q && (sign_in != last_sign_q);
   assign timed_out = (cnt_q + 13'h0001) >= limit_q;
   assign pending   = (state_q == ST_WAIT);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         last_sign_q  <= 1'b0;
         sign_valid_q <= 1'b0;
      end else if (clear) begin
         sign_valid_q <= 1'b0;
      end else if (sample_tick) begin
         last_sign_q  <= sign_in;
         sign_valid_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q      <= ST_IDLE;
         applied_gain <= GAIN_RST;
         target_q     <= GAIN_RST;
         limit_q      <= HR_TMO_2;
         cnt_q        <= 13'h0000;
      end else if (clear) begin
         state_q      <= ST_IDLE;
         applied_gain <= GAIN_RST;
         cnt_q        <= 13'h0000;
      end else if (req && !req_zc) begin
         applied_gain <= req_value;
         state_q      <= ST_IDLE;
      end else if (req) begin
         // A rewrite while waiting keeps the running count, so the new value may land sooner.
         target_q <= req_value;
         limit_q  <= req_limit;
         state_q  <= ST_WAIT;
         if (state_q == ST_IDLE) begin
            cnt_q <= 13'h0000;
         end
      end else begin
         case (state_q)
            ST_WAIT: begin
               if (sample_tick && (zc_seen || timed_out)) begin
                  applied_gain <= target_q;
                  state_q      <= ST_IDLE;
               end else if (sample_tick) begin
                  cnt_q <= cnt_q + 13'h0001;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

endmodule // gain_change_unit

`default_nettype wire

//--- design/codec_mode_regs.sv
`timescale 1ns/100ps
`default_nettype none

module codec_mode_regs
   import codec_mode_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              reset_n,
   input  wire logic              power_down_n,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   input  wire logic              sample_tick,
   input  wire chan_pair_t        adc_sign,
   input  wire logic              limiter_step_req,
   input  wire logic [GAIN_W-1:0] limiter_step_gain,
   output logic                   limiter_step_ready,
   input  wire logic              recovery_step_req,
   input  wire logic [GAIN_W-1:0] recovery_step_gain,
   output input_source_t          input_source,
   output power_ctrl_t            power_ctrl,
   output serial_format_t         serial_format,
   output logic      [1:0]        mono_mix_sel,
   output logic                   deemph_active,
   output deemph_rate_t           deemph_rate,
   output logic                   input_range_sel,
   output logic      [GAIN_W-1:0] left_gain_applied,
   output logic      [GAIN_W-1:0] right_gain_applied,
   output chan_pair_t             gain_pending
);

   logic              pd_meta_q;
   logic              pd_sync_q;
   logic              active;

   input_source_t     input_source_q;
   power_mgmt_t       power_mgmt_q;
   format_t           format_q;
   timing_t           timing_q;
   logic [GAIN_W-1:0] left_gain_value_q;
   logic [GAIN_W-1:0] right_gain_value_q;

   logic              ack_q;
   logic [31:0]       rd_data_q;
   logic [31:0]       rd_data;
   logic              addr_ok;
   logic [2:0]        idx;
   logic              wr_fire;

   power_ctrl_t       power_ctrl_q;
   deemph_rate_t      deemph_rate_q;
   logic              deemph_active_q;

   logic [TMO_W-1:0]  hr_limit;
   logic [TMO_W-1:0]  lim_limit;
   logic [TMO_W-1:0]  lim_period;
   logic [TMO_W-1:0]  lim_gap_q;
   logic              lim_ready_q;
   logic              lim_fire;
   logic              rec_fire;

   logic [1:0]              host_wr;
   logic [1:0]              ch_req;
   logic [1:0]              ch_zc;
   logic [1:0]              ch_sign;
   logic [1:0]              ch_pending;
   logic [GAIN_W-1:0]       ch_value   [2];
   logic [TMO_W-1:0]        ch_limit   [2];
   logic [GAIN_W-1:0]       ch_applied [2];
   status_t                 status;

   // The pin is asynchronous to core_clk, so it is synchronised before use.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pd_meta_q <= 1'b0;
         pd_sync_q <= 1'b0;
      end else begin
         pd_meta_q <= power_down_n;
         pd_sync_q <= pd_meta_q;
      end
   end

   assign active = pd_sync_q;

   assign idx     = wb_adr_i[4:2];
   assign addr_ok = (wb_adr_i[ADDR_W-1:5] == 3'h0) && (wb_adr_i[1:0] == 2'h0) && (idx <= IDX_STATUS);

   // Writes land on the edge where the master sees ack, never earlier.
   assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0] && addr_ok && active;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      case (idx)
         IDX_INPUT_SOURCE: rd_data[7:0] = input_source_q;
         IDX_POWER_MGMT:   rd_data[7:0] = power_mgmt_q;
         IDX_FORMAT:       rd_data[7:0] = format_q;
         IDX_GAIN_TIMING:  rd_data[7:0] = timing_q;
         IDX_GAIN_LEFT:    rd_data[GAIN_W-1:0] = left_gain_value_q;
         IDX_GAIN_RIGHT:   rd_data[GAIN_W-1:0] = right_gain_value_q;
         IDX_STATUS:       rd_data = status;
         default:          rd_data = 32'h0000_0000;
      endcase
      if (!addr_ok) begin
         rd_data = 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data_q <= 32'h0000_0000;
      end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
         rd_data_q <= rd_data;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rd_data_q;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         input_source_q <= INPUT_SOURCE_RST;
      end else if (!active) begin
         input_source_q <= INPUT_SOURCE_RST;
      end else if (wr_fire && idx == IDX_INPUT_SOURCE) begin
         input_source_q          <= wb_dat_i[7:0];
         input_source_q.reserved <= 4'h0;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         power_mgmt_q <= POWER_MGMT_RST;
      end else if (!active) begin
         power_mgmt_q <= POWER_MGMT_RST;
      end else if (wr_fire && idx == IDX_POWER_MGMT) begin
         power_mgmt_q          <= wb_dat_i[7:0];
         power_mgmt_q.reserved <= 4'h0;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         format_q <= FORMAT_RST;
      end else if (!active) begin
         format_q <= FORMAT_RST;
      end else if (wr_fire && idx == IDX_FORMAT) begin
         format_q          <= wb_dat_i[7:0];
         format_q.reserved <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         timing_q <= GAIN_TIMING_RST;
      end else if (!active) begin
         timing_q <= GAIN_TIMING_RST;
      end else if (wr_fire && idx == IDX_GAIN_TIMING) begin
         timing_q <= wb_dat_i[7:0];
      end
   end

   // In linked mode a left write also lands in the right register; a right write stays right.
   assign host_wr[0] = wr_fire && (idx == IDX_GAIN_LEFT);
   assign host_wr[1] = wr_fire && ((idx == IDX_GAIN_RIGHT) ||
                                   (idx == IDX_GAIN_LEFT && timing_q.gain_link_mode));

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         left_gain_value_q <= GAIN_RST;
      end else if (!active) begin
         left_gain_value_q <= GAIN_RST;
      end else if (host_wr[0]) begin
         left_gain_value_q <= wb_dat_i[GAIN_W-1:0];
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         right_gain_value_q <= GAIN_RST;
      end else if (!active) begin
         right_gain_value_q <= GAIN_RST;
      end else if (host_wr[1]) begin
         right_gain_value_q <= wb_dat_i[GAIN_W-1:0];
      end
   end

   // Derived power controls are registered so the analog side never sees a decode glitch.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         power_ctrl_q <= 7'h00;
      end else begin
         power_ctrl_q.device_on         <= active && (power_mgmt_q[3:0] != 4'h0);
         power_ctrl_q.front_end_on      <= active && power_mgmt_q.front_end_power;
         power_ctrl_q.adc_on            <= active && power_mgmt_q.adc_power;
         power_ctrl_q.dac_on            <= active && power_mgmt_q.dac_power;
         power_ctrl_q.loopback_on       <= active && power_mgmt_q.loopback_power_select;
         power_ctrl_q.amp_from_loopback <= power_mgmt_q.loopback_power_select;
         power_ctrl_q.out_amp_on        <= active && (power_mgmt_q.dac_power ||
                                                      power_mgmt_q.loopback_power_select);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         deemph_active_q <= 1'b0;
         deemph_rate_q   <= DEEMPH_OFF;
      end else begin
         // The rate field only matters with the enable bit set.
         deemph_active_q <= format_q.deemph_enable && (format_q.deemph_rate_sel != DEEMPH_OFF);
         deemph_rate_q   <= format_q.deemph_enable ? format_q.deemph_rate_sel : DEEMPH_OFF;
      end
   end

   always_comb begin
      case (timing_q.host_recovery_timeout_sel)
         2'h0:    hr_limit = HR_TMO_0;
         2'h1:    hr_limit = HR_TMO_1;
         2'h2:    hr_limit = HR_TMO_2;
         default: hr_limit = HR_TMO_3;
      endcase
   end

   always_comb begin
      case (timing_q.limiter_timing_sel)
         2'h0: begin
            lim_limit  = LIM_TMO_0;
            lim_period = LIM_UPD_0;
         end
         2'h1: begin
            lim_limit  = LIM_TMO_1;
            lim_period = LIM_UPD_1;
         end
         2'h2: begin
            lim_limit  = LIM_TMO_2;
            lim_period = LIM_UPD_2;
         end
         default: begin
            lim_limit  = LIM_TMO_3;
            lim_period = LIM_UPD_3;
         end
      endcase
   end

   assign lim_fire = limiter_step_req && lim_ready_q;
   assign rec_fire = recovery_step_req && active && !lim_fire;

   // Without zero-cross waiting the limiter is paced by the update period instead.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         lim_gap_q <= 13'h0000;
      end else if (!active) begin
         lim_gap_q <= 13'h0000;
      end else if (lim_fire) begin
         lim_gap_q <= timing_q.limiter_zc_enable ? 13'h0000 : lim_period;
      end else if (sample_tick && lim_gap_q != 13'h0000) begin
         lim_gap_q <= lim_gap_q - 13'h0001;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         lim_ready_q <= 1'b0;
      end else begin
         lim_ready_q <= power_ctrl_q.front_end_on && !lim_fire && (lim_gap_q == 13'h0000) &&
                        !(timing_q.limiter_zc_enable && (ch_pending != 2'h0));
      end
   end

   assign ch_sign[0] = adc_sign.left;
   assign ch_sign[1] = adc_sign.right;

   // Limiter wins over recovery, recovery over a host write.
   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_chan
         always_comb begin
            ch_req[ch]   = lim_fire || rec_fire || host_wr[ch];
            ch_value[ch] = wb_dat_i[GAIN_W-1:0];
            ch_zc[ch]    = timing_q.host_recovery_zc_enable;
            ch_limit[ch] = hr_limit;
            if (lim_fire) begin
               ch_value[ch] = limiter_step_gain;
               ch_zc[ch]    = timing_q.limiter_zc_enable;
               ch_limit[ch] = lim_limit;
            end else if (rec_fire) begin
               ch_value[ch] = recovery_step_gain;
            end
         end

         gain_change_unit u_unit (
            .core_clk     (core_clk),
            .reset_n      (reset_n),
            .clear        (!active),
            .sample_tick  (sample_tick),
            .sign_in      (ch_sign[ch]),
            .req          (ch_req[ch]),
            .req_value    (ch_value[ch]),
            .req_zc       (ch_zc[ch]),
            .req_limit    (ch_limit[ch]),
            .applied_gain (ch_applied[ch]),
            .pending      (ch_pending[ch])
         );
      end
   endgenerate

   always_comb begin
      status               = 32'h0000_0000;
      status.left_pending  = ch_pending[0];
      status.right_pending = ch_pending[1];
      status.left_gain     = ch_applied[0];
      status.right_gain    = ch_applied[1];
      status.device_on     = power_ctrl_q.device_on;
   end

   assign limiter_step_ready  = lim_ready_q;
   assign input_source        = input_source_q;
   assign power_ctrl          = power_ctrl_q;
   // Every format keeps two's complement, MSB first; only justification and clock ratio differ.
   assign serial_format       = format_q.serial_format_sel;
   assign mono_mix_sel        = format_q.mono_mix_sel;
   assign deemph_active       = deemph_active_q;
   assign deemph_rate         = deemph_rate_q;
   assign input_range_sel     = timing_q.input_range_sel;
   assign left_gain_applied   = ch_applied[0];
   assign right_gain_applied  = ch_applied[1];
   assign gain_pending.left   = ch_pending[0];
   assign gain_pending.right  = ch_pending[1];

endmodule // codec_mode_regs

`default_nettype wire

//--- bench/codec_mode_regs_properties.sv
`timescale 1ns/100ps
`default_nettype none
module codec_mode_regs_properties
   import codec_mode_pkg::*;
(
   input wire logic          core_clk,
   input wire logic          reset_n,
   input wire logic          power_down_n,
   input wire logic          wb_cyc_i,
   input wire logic          wb_stb_i,
   input wire logic          wb_ack_o,
   input wire logic          limiter_step_req,
   input wire logic          limiter_step_ready,
   input wire logic          deemph_active,
   input wire deemph_rate_t  deemph_rate,
   input wire power_ctrl_t   power_ctrl,
   input wire input_source_t input_source
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   chk_ack_follows_req:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
   chk_ack_one_pulse:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   chk_deemph_rate_off:
      assert property (!deemph_active |-> deemph_rate == DEEMPH_OFF) else $error("rate not off");
   chk_device_off_all:
      assert property (power_ctrl.device_on == (power_ctrl.front_end_on || power_ctrl.adc_on
         || power_ctrl.dac_on || power_ctrl.loopback_on)) else $error("device power wrong");
   chk_amp_needs_src:
      assert property (power_ctrl.out_amp_on == (power_ctrl.dac_on || power_ctrl.loopback_on))
         else $error("amp power wrong");
   chk_amp_steer_loop:
      assert property (power_ctrl.out_amp_on |-> power_ctrl.amp_from_loopback == power_ctrl.loopback_on)
         else $error("amp steering wrong");
   chk_pin_holds_reset:
      assert property (!power_down_n [*5] |-> input_source == INPUT_SOURCE_RST && power_ctrl == '0)
         else $error("power-down not holding");
   chk_limiter_busy:
      assert property (limiter_step_req && limiter_step_ready |=> !limiter_step_ready)
         else $error("limiter ready after step");
endmodule // codec_mode_regs_properties
bind codec_mode_regs codec_mode_regs_properties codec_mode_regs_properties_i (.core_clk, .reset_n,
   .power_down_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .limiter_step_req, .limiter_step_ready,
   .deemph_active, .deemph_rate, .power_ctrl, .input_source);
`default_nettype wire

//--- bench/codec_mode_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module codec_mode_regs_tb
   import codec_mode_pkg::*;
;
   logic              core_clk, reset_n, power_down_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]        wb_adr_i;
   logic [3:0]        wb_sel_i;
   logic [31:0]       wb_dat_i, wb_dat_o, q;
   logic              sample_tick, limiter_step_req, limiter_step_ready, recovery_step_req;
   logic [GAIN_W-1:0] limiter_step_gain, recovery_step_gain, left_gain_applied, right_gain_applied;
   chan_pair_t        adc_sign, gain_pending;
   input_source_t     input_source;
   power_ctrl_t       power_ctrl;
   serial_format_t    serial_format;
   deemph_rate_t      deemph_rate;
   logic [1:0]        mono_mix_sel;
   logic              deemph_active, input_range_sel;
   int                n_fail, samples_checked;
   codec_mode_regs codec_mode_regs_i (.core_clk, .reset_n, .power_down_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sample_tick, .adc_sign, .limiter_step_req,
      .limiter_step_gain, .limiter_step_ready, .recovery_step_req, .recovery_step_gain, .input_source,
      .power_ctrl, .serial_format, .mono_mix_sel, .deemph_active, .deemph_rate, .input_range_sel,
      .left_gain_applied, .right_gain_applied, .gain_pending);
   initial begin
      core_clk = 0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // The master holds the request until the edge at which ack is seen, then idles one cycle.
   task automatic wb(input logic we, input logic [2:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {3'h0, idx, 2'h0};
      wb_dat_i <= {24'h00_0000, d};
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge core_clk);
      if (n >= 20) begin
         n_fail++;
         print_verdict();
      end
   endtask
   task automatic tick(input int n, input logic s);
      repeat (n) begin
         sample_tick <= 1'b1;
         adc_sign    <= {s, s};
         @(posedge core_clk);
         sample_tick <= 1'b0;
         @(posedge core_clk);
      end
   endtask
   task automatic t_reset;
      logic [7:0] rv [4] = '{8'h05, 8'h07, 8'h00, 8'hE4};
      for (int i = 0; i < 4; i++) begin
         wb(0, i[2:0], 8'h00);
         chk("reset value", q, {24'h0, rv[i]});
      end
      wb(1, 3'h7, 8'hFF);
      wb(0, 3'h7, 8'h00);
      chk("unmapped", q, 32'h0000_0000);
      chk("range", input_range_sel, 1'b1);
      $display("test reset done");
   endtask
   task automatic t_inputs;
      wb(1, 3'h0, 8'hFA);
      wb(0, 3'h0, 8'h00);
      chk("src read", q, 32'h0000_000A);
      chk("src out", input_source, 8'h0A);
      $display("test inputs done");
   endtask
   task automatic t_power;
      for (int v = 0; v < 16; v++) begin
         wb(1, 3'h1, v[7:0]);
         @(posedge core_clk);
         chk("power", power_ctrl, {v[0], v[1], v[2], v[3], v[2] | v[3], v[3], |v[3:0]});
      end
      $display("test power done");
   endtask
   task automatic t_format;
      logic [7:0] d;
      for (int i = 0; i < 32; i++) begin
         d = {2'b11, i[3:0], i[4], 1'b1};
         wb(1, 3'h2, d);
         wb(0, 3'h2, 8'h00);
         chk("fmt read", q, {24'h0, d & 8'hFE});
         chk("fmt", {mono_mix_sel, serial_format}, {2'b11, i[3:2]});
         chk("rate", deemph_rate, i[4] ? i[1:0] : 2'b01);
         chk("deemph on", deemph_active, i[4] && (i[1:0] != 2'b01));
      end
      $display("test format done");
   endtask
   task automatic t_gain;
      wb(1, 3'h3, 8'h80);
      chk("line range", input_range_sel, 1'b0);
      wb(1, 3'h4, 8'h2A);
      wb(1, 3'h5, 8'h15);
      wb(1, 3'h3, 8'h00);
      wb(1, 3'h4, 8'h33);
      chk("gains", {left_gain_applied, right_gain_applied}, {7'h33, 7'h15});
      wb(1, 3'h3, 8'h80);
      wb(1, 3'h4, 8'h2A);
      wb(0, 3'h5, 8'h00);
      chk("linked", {q[6:0], right_gain_applied}, {7'h2A, 7'h2A});
      wb(1, 3'h3, 8'h08);
      tick(2, 0);
      wb(1, 3'h4, 8'h40);
      chk("pending", gain_pending, 2'b10);
      tick(1, 1);
      chk("crossing", {left_gain_applied, gain_pending}, {7'h40, 2'b00});
      wb(1, 3'h5, 8'h11);
      tick(512, 1);
      chk("waiting", {right_gain_applied, gain_pending}, {7'h2A, 2'b01});
      tick(1, 1);
      chk("timeout", {right_gain_applied, gain_pending}, {7'h11, 2'b00});
      wb(0, 3'h6, 8'h00);
      chk("status", q, 32'h0111_4000);
      $display("test gain done");
   endtask
   task automatic t_limiter;
      for (int c = 0; c < 4; c++) begin
         wb(1, 3'h3, {5'h00, c[1:0], 1'b0});
         tick(8, 0);
         limiter_step_req  <= 1'b1;
         limiter_step_gain <= 7'h10 + c[6:0];
         @(posedge core_clk);
         limiter_step_req <= 1'b0;
         @(posedge core_clk);
         chk("step", {left_gain_applied, right_gain_applied}, {2{7'h10 + c[6:0]}});
         tick((1 << c) - 1, 0);
         chk("spacing", limiter_step_ready, 1'b0);
         tick(1, 0);
         @(posedge core_clk);
         chk("ready", limiter_step_ready, 1'b1);
      end
      wb(1, 3'h3, 8'h01);
      limiter_step_req  <= 1'b1;
      limiter_step_gain <= 7'h20;
      @(posedge core_clk);
      limiter_step_req <= 1'b0;
      @(posedge core_clk);
      chk("lim wait", {gain_pending, limiter_step_ready}, 3'b110);
      tick(1, 1);
      chk("lim zc", {left_gain_applied, right_gain_applied, gain_pending}, {7'h20, 7'h20, 2'b00});
      recovery_step_req  <= 1'b1;
      recovery_step_gain <= 7'h05;
      @(posedge core_clk);
      recovery_step_req <= 1'b0;
      @(posedge core_clk);
      chk("recovery", {left_gain_applied, right_gain_applied}, {7'h05, 7'h05});
      $display("test limiter done");
   endtask
   task automatic t_pin;
      power_down_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      wb(1, 3'h0, 8'h0F);
      wb(0, 3'h0, 8'h00);
      chk("held", {q[7:0], power_ctrl, left_gain_applied}, {8'h05, 7'h00, 7'h00});
      power_down_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      $display("test pin done");
   endtask
   initial begin
      {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, sample_tick, adc_sign} = '0;
      {limiter_step_req, limiter_step_gain, recovery_step_req, recovery_step_gain} = '0;
      wb_sel_i     = 4'h1;
      power_down_n = 1'b1;
      n_fail          = 0;
      samples_checked = 0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      t_reset();
      t_inputs();
      t_power();
      t_format();
      t_gain();
      t_limiter();
      t_pin();
      print_verdict();
   end
endmodule // codec_mode_regs_tb
`default_nettype wire
